//--- isoch_rx_context_status.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module isoch_rx_context_status
	import isoch_rx_pkg::*;
#(
	parameter int CONTEXTS = isoch_rx_pkg::CONTEXT_COUNT
)
(
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// axi4-lite slave
	input  wire logic [15:0]                  s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [15:0]                  s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// descriptor fetch and receive datapath, per context
	input  wire logic [CONTEXTS-1:0]          fetch_done,
	input  wire logic [CONTEXTS*32-1:0]       fetch_next,
	input  wire logic [CONTEXTS-1:0]          list_end,
	input  wire logic [CONTEXTS-1:0]          fatal_error,
	input  wire logic [CONTEXTS-1:0]          pkt_done,
	input  wire logic [CONTEXTS*3-1:0]        pkt_speed,
	input  wire logic [CONTEXTS*3-1:0]        pkt_outcome,
	output logic [CONTEXTS-1:0]               fetch_req,
	output logic [CONTEXTS*32-1:0]            fetch_addr,
	output logic [CONTEXTS-1:0]               pkt_backout
);
	import isoch_rx_pkg::*;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        aw_held;
		logic [15:0] awaddr;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} bus_t;

	bus_t cur;
	bus_t next_cur;

	logic [CONTEXTS-1:0]    run_set;
	logic [CONTEXTS-1:0]    run_clear;
	logic [CONTEXTS-1:0]    packed_set;
	logic [CONTEXTS-1:0]    packed_clear;
	logic [CONTEXTS-1:0]    ptr_load;
	logic [CONTEXTS*32-1:0] status_word;
	logic [CONTEXTS*32-1:0] descriptor_pointer;
	logic                   do_write;

	// ---------------------------------------------------------------
	// contexts
	// ---------------------------------------------------------------
	// one instance per context
	for (genvar n = 0; n < CONTEXTS; n++)
	begin : g_ctx
		isoch_rx_context u_ctx (
			.clk                (clk),
			.sys_rst            (sys_rst),
			.run_set            (run_set[n]),
			.run_clear          (run_clear[n]),
			.packed_set         (packed_set[n]),
			.packed_clear       (packed_clear[n]),
			.ptr_load           (ptr_load[n]),
			.ptr_value          (cur.wdata),
			.fetch_done         (fetch_done[n]),
			.fetch_next         (fetch_next[n*32 +: 32]),
			.list_end           (list_end[n]),
			.fatal_error        (fatal_error[n]),
			.pkt_done           (pkt_done[n]),
			.pkt_speed          (pkt_speed[n*3 +: 3]),
			.pkt_outcome        (rx_outcome_t'(pkt_outcome[n*3 +: 3])),
			.fetch_req          (fetch_req[n]),
			.fetch_addr         (fetch_addr[n*32 +: 32]),
			.pkt_backout        (pkt_backout[n]),
			.status_word        (status_word[n*32 +: 32]),
			.descriptor_pointer (descriptor_pointer[n*32 +: 32])
		);
	end

	// ---------------------------------------------------------------
	// write decode
	// ---------------------------------------------------------------
	// set/clear pair avoids read-modify-write races with hardware
	assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;

	always_comb
	begin
		logic [15:0] ofs;
		ofs          = '0;
		run_set      = '0;
		run_clear    = '0;
		packed_set   = '0;
		packed_clear = '0;
		ptr_load     = '0;
		for (int n = 0; n < CONTEXTS; n++)
		begin
			ofs = 16'(CONTROL_BASE + 16'(n) * CONTEXT_STRIDE);
			if (do_write && cur.awaddr == 16'(ofs + CONTROL_SET_OFS))
			begin
				run_set[n]    = cur.wstrb[1] && cur.wdata[BIT_RUN];
				packed_set[n] = cur.wstrb[3] && cur.wdata[BIT_PACKED];
			end
			if (do_write && cur.awaddr == 16'(ofs + CONTROL_CLEAR_OFS))
			begin
				run_clear[n]    = cur.wstrb[1] && cur.wdata[BIT_RUN];
				packed_clear[n] = cur.wstrb[3] && cur.wdata[BIT_PACKED];
			end
			if (do_write && cur.awaddr == 16'(ofs + PTR_LOAD_OFS))
				ptr_load[n] = &cur.wstrb;
		end
	end

	// ---------------------------------------------------------------
	// bus sequencing
	// ---------------------------------------------------------------
	always_comb
	begin
		logic        hit;
		logic [15:0] ofs;
		hit      = 1'b0;
		ofs      = '0;
		next_cur = cur;
		if (s_axi_awvalid && !cur.aw_held)
		begin
			next_cur.aw_held = 1'b1;
			next_cur.awaddr  = {s_axi_awaddr[15:2], 2'b00};
		end
		if (s_axi_wvalid && !cur.w_held)
		begin
			next_cur.w_held = 1'b1;
			next_cur.wdata  = s_axi_wdata;
			next_cur.wstrb  = s_axi_wstrb;
		end
		if (do_write)
		begin
			// pointer offset itself is accepted and ignored
			hit = 1'b0;
			for (int n = 0; n < CONTEXTS; n++)
			begin
				ofs = 16'(CONTROL_BASE + 16'(n) * CONTEXT_STRIDE);
				if (cur.awaddr >= ofs && cur.awaddr <= 16'(ofs + DESC_PTR_BASE - CONTROL_BASE))
					hit = 1'b1;
			end
			next_cur.aw_held = 1'b0;
			next_cur.w_held  = 1'b0;
			next_cur.bvalid  = 1'b1;
			next_cur.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (cur.bvalid && s_axi_bready)
			next_cur.bvalid = 1'b0;
		if (s_axi_arvalid && !cur.rvalid)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rdata  = '0;
			next_cur.rresp  = RESP_SLVERR;
			for (int n = 0; n < CONTEXTS; n++)
			begin
				ofs = 16'(CONTROL_BASE + 16'(n) * CONTEXT_STRIDE);
				if ({s_axi_araddr[15:2], 2'b00} == 16'(ofs + CONTROL_SET_OFS) ||
				    {s_axi_araddr[15:2], 2'b00} == 16'(ofs + CONTROL_CLEAR_OFS))
				begin
					next_cur.rdata = status_word[n*32 +: 32];
					next_cur.rresp = RESP_OKAY;
				end
				if ({s_axi_araddr[15:2], 2'b00} == 16'(DESC_PTR_BASE + 16'(n) * CONTEXT_STRIDE))
				begin
					next_cur.rdata = descriptor_pointer[n*32 +: 32];
					next_cur.rresp = RESP_OKAY;
				end
			end
		end
		else if (cur.rvalid && s_axi_rready)
			next_cur.rvalid = 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// handshake outputs
	assign s_axi_awready = !cur.aw_held;
	assign s_axi_wready  = !cur.w_held;
	assign s_axi_bvalid  = cur.bvalid;
	assign s_axi_bresp   = cur.bresp;
	assign s_axi_arready = !cur.rvalid;
	assign s_axi_rvalid  = cur.rvalid;
	assign s_axi_rdata   = cur.rdata;
	assign s_axi_rresp   = cur.rresp;

endmodule : isoch_rx_context_status

//--- isoch_rx_pkg.sv
package isoch_rx_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int          CONTEXT_COUNT     = 4;
	localparam logic [15:0] DESC_PTR_BASE     = 16'h040c;  // context n at base + stride * n
	localparam logic [15:0] CONTEXT_STRIDE    = 16'h0020;
	localparam logic [15:0] CONTROL_BASE      = 16'h0400;  // control/status, same stride
	localparam logic [15:0] CONTROL_SET_OFS   = 16'h0000;
	localparam logic [15:0] CONTROL_CLEAR_OFS = 16'h0004;
	localparam logic [15:0] PTR_LOAD_OFS      = 16'h0008;  // software seed for the pointer

	// ---------------------------------------------------------------
	// control/status field positions
	// ---------------------------------------------------------------
	localparam int BIT_PACKED  = 31;
	localparam int BIT_RUN     = 15;
	localparam int BIT_HALTED  = 11;
	localparam int BIT_BUSY    = 10;
	localparam int SPEED_LSB   = 5;
	localparam int EVENT_LSB   = 0;

	// ---------------------------------------------------------------
	// receive speed codes
	// ---------------------------------------------------------------
	localparam logic [2:0] SPEED_100 = 3'h0;
	localparam logic [2:0] SPEED_200 = 3'h1;
	localparam logic [2:0] SPEED_400 = 3'h2;

	// ---------------------------------------------------------------
	// completion event codes
	// ---------------------------------------------------------------
	localparam logic [4:0] EVT_NONE            = 5'h00;
	localparam logic [4:0] EVT_LONG_PACKET     = 5'h02;
	localparam logic [4:0] EVT_DESCRIPTOR_READ = 5'h05;
	localparam logic [4:0] EVT_DATA_WRITE      = 5'h07;
	localparam logic [4:0] EVT_OVERRUN         = 5'h0c;
	localparam logic [4:0] EVT_UNKNOWN         = 5'h0e;
	localparam logic [4:0] ACK_COMPLETE        = 5'h11;
	localparam logic [4:0] ACK_DATA_ERROR      = 5'h1d;

	// packet outcome reported by the receive datapath
	typedef enum logic [2:0] {
		RX_OK       = 3'h0,
		RX_LEN_ERR  = 3'h1,
		RX_CRC_ERR  = 3'h2,
		RX_OVERRUN  = 3'h3,
		RX_LONG     = 3'h4,
		RX_UNKNOWN  = 3'h5
	} rx_outcome_t;

	// context sequencer states, gray along idle-fetch-busy-stop
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_BUSY  = 2'b11,
		ST_STOP  = 2'b10
	} ctx_state_t;

endpackage : isoch_rx_pkg

//--- isoch_rx_context.sv
`timescale 1ns/100ps
// one receive context: enable, halted and busy flags, status fields, pointer
module isoch_rx_context
	import isoch_rx_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 run_set,
	input  wire logic                 run_clear,
	input  wire logic                 packed_set,
	input  wire logic                 packed_clear,
	input  wire logic                 ptr_load,
	input  wire logic [31:0]          ptr_value,
	input  wire logic                 fetch_done,
	input  wire logic [31:0]          fetch_next,
	input  wire logic                 list_end,
	input  wire logic                 fatal_error,
	input  wire logic                 pkt_done,
	input  wire logic [2:0]           pkt_speed,
	input  wire isoch_rx_pkg::rx_outcome_t pkt_outcome,
	output logic                      fetch_req,
	output logic [31:0]               fetch_addr,
	output logic                      pkt_backout,
	output logic [31:0]               status_word,
	output logic [31:0]               descriptor_pointer
);
	import isoch_rx_pkg::*;

	typedef struct packed {
		ctx_state_t  state;
		logic        run;
		logic        packed_mode;
		logic        halted;
		logic [2:0]  speed;
		logic [4:0]  event_code;
		logic        backout;
		logic [31:0] pointer;
	} ctx_t;

	ctx_t cur;
	ctx_t next_cur;

	// ---------------------------------------------------------------
	// sequencer and status update
	// ---------------------------------------------------------------
	always_comb
	begin
		next_cur         = cur;
		next_cur.backout = 1'b0;
		if (run_set)
			next_cur.run = 1'b1;
		if (run_clear)
		begin
			next_cur.run    = 1'b0;  // only software moves the enable
			next_cur.halted = 1'b0;
		end
		// mode may only change while stopped and idle
		if (!cur.run && cur.state == ST_IDLE)
		begin
			if (packed_set)
				next_cur.packed_mode = 1'b1;
			if (packed_clear)
				next_cur.packed_mode = 1'b0;
			if (ptr_load)
				next_cur.pointer = ptr_value;
		end
		unique case (cur.state)
			ST_IDLE:
			begin
				// only a fresh enable starts a fetch, so an ended list stays idle
				if (run_set && !cur.halted)
					next_cur.state = ST_FETCH;  // first block from pointer
			end
			ST_FETCH:
			begin
				if (fetch_done)
				begin
					next_cur.pointer    = fetch_next;
					next_cur.event_code = EVT_NONE;
					next_cur.state      = ST_BUSY;
				end
			end
			ST_BUSY:
			begin
				if (pkt_done)
				begin
					next_cur.speed = pkt_speed;
					if (cur.packed_mode)
					begin
						// bad packets are rewound out of the buffer
						unique case (pkt_outcome)
							RX_LEN_ERR, RX_CRC_ERR, RX_OVERRUN: next_cur.backout = 1'b1;
							RX_OK, RX_LONG: next_cur.event_code = ACK_COMPLETE;
							default: next_cur.event_code = EVT_UNKNOWN;
						endcase
					end
					else
					begin
						unique case (pkt_outcome)
							RX_OK:                  next_cur.event_code = ACK_COMPLETE;
							RX_LEN_ERR, RX_CRC_ERR: next_cur.event_code = ACK_DATA_ERROR;
							RX_OVERRUN:             next_cur.event_code = EVT_OVERRUN;
							RX_LONG:                next_cur.event_code = EVT_LONG_PACKET;
							default:                next_cur.event_code = EVT_UNKNOWN;
						endcase
						next_cur.state = ST_FETCH;  // one packet per buffer
					end
				end
				if (list_end)
					next_cur.state = ST_STOP;
			end
			ST_STOP:
				next_cur.state = ST_IDLE;
		endcase
		// a stopped or failed context drops busy
		// stop must still fall through to idle, or mode and pointer stay locked
		if (cur.state != ST_IDLE && cur.state != ST_STOP && (!next_cur.run || list_end))
			next_cur.state = ST_STOP;
		if (fatal_error && cur.state != ST_IDLE)
		begin
			next_cur.halted     = 1'b1;  // set wins over clear
			next_cur.state      = ST_STOP;
			next_cur.event_code = (cur.state == ST_FETCH) ? EVT_DESCRIPTOR_READ : EVT_DATA_WRITE;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign fetch_req          = (cur.state == ST_FETCH);
	assign fetch_addr         = cur.pointer;
	assign pkt_backout        = cur.backout;
	assign descriptor_pointer = cur.pointer;  // read only to software

	// reserved bits read zero
	always_comb
	begin
		status_word                                = '0;
		status_word[BIT_PACKED]                    = cur.packed_mode;
		status_word[BIT_RUN]                       = cur.run;
		status_word[BIT_HALTED]                    = cur.halted;
		status_word[BIT_BUSY]                      = (cur.state == ST_FETCH) || (cur.state == ST_BUSY);
		status_word[SPEED_LSB +: 3]                = cur.speed;
		status_word[EVENT_LSB +: 5]                = cur.event_code;
	end

endmodule : isoch_rx_context

//--- isoch_rx_descriptor_memory.sv
`timescale 1ns/100ps
// ------------------------------
// descriptor memory model
// ------------------------------
module isoch_rx_descriptor_memory
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         slow,
	input  wire logic [3:0]   fetch_req,
	input  wire logic [127:0] fetch_addr,
	output logic      [3:0]   fetch_done,
	output logic      [127:0] fetch_next
);
	genvar n;
	for (n = 0; n < 4; n++)
	begin : g_ctx
		logic [3:0] cnt;
		// answer a fetch after a short or long wait
		always_ff @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				cnt <= 4'h0;
				fetch_done[n] <= 1'b0;
			end
			else if (fetch_req[n] && !fetch_done[n])
			begin
				cnt <= cnt + 4'h1;
				fetch_done[n] <= cnt >= (slow ? 4'h6 : 4'h0);
			end
			else
			begin
				cnt <= 4'h0;
				fetch_done[n] <= 1'b0;
			end
		end
		// outside the done cycle the data lines show garbage
		assign fetch_next[n*32 +: 32] = fetch_done[n] ? fetch_addr[n*32 +: 32] + 32'h20
			: ~(fetch_addr[n*32 +: 32] + 32'h20);
	end
endmodule : isoch_rx_descriptor_memory

//--- isoch_rx_context_status_properties.sv
`timescale 1ns/100ps
// ------------------------------
// port checker, context 0
// ------------------------------
module isoch_rx_context_status_properties
	import isoch_rx_pkg::*;
#(
	parameter int CONTEXTS = 4
)
(
	input wire logic                  clk,
	input wire logic                  sys_rst,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [CONTEXTS-1:0]   fetch_done,
	input wire logic [CONTEXTS*32-1:0] fetch_next,
	input wire logic [CONTEXTS-1:0]   list_end,
	input wire logic [CONTEXTS-1:0]   fatal_error,
	input wire logic [CONTEXTS-1:0]   pkt_done,
	input wire logic [CONTEXTS*3-1:0] pkt_outcome,
	input wire logic [CONTEXTS-1:0]   fetch_req,
	input wire logic [CONTEXTS*32-1:0] fetch_addr,
	input wire logic [CONTEXTS-1:0]   pkt_backout
);
	import isoch_rx_pkg::*;
	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_backout_cause;
		pkt_backout[0] |-> $past(pkt_done[0]) && ($past(pkt_outcome[2:0]) inside {3'h1, 3'h2, 3'h3});
	endproperty
	a_backout_cause: assert property (p_backout_cause)
		else $error("backout without a bad packet");
	property p_fatal_stop;
		fatal_error[0] |=> !fetch_req[0] [*3];
	endproperty
	a_fatal_stop: assert property (p_fatal_stop)
		else $error("fetch goes on after fatal error");
	property p_end_stop;
		list_end[0] |-> ##1 !fetch_req[0] ##1 !fetch_req[0];
	endproperty
	a_end_stop: assert property (p_end_stop)
		else $error("fetch goes on after list end");
	property p_ptr_next;
		fetch_done[0] && fetch_req[0] |=> fetch_addr[31:0] == $past(fetch_next[31:0]);
	endproperty
	a_ptr_next: assert property (p_ptr_next)
		else $error("pointer not advanced by fetch");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once)
		else $error("write response repeated");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once)
		else $error("read response repeated");
	property p_r_next;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_next: assert property (p_r_next)
		else $error("read answer late after address taken");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero)
		else $error("error read carries data");
endmodule : isoch_rx_context_status_properties
bind isoch_rx_context_status isoch_rx_context_status_properties
	#(.CONTEXTS(CONTEXTS)) i_isoch_rx_context_status_properties (.*);

//--- isoch_rx_context_status_tb.sv
`timescale 1ns/100ps
// ------------------------------
// register and context bench
// ------------------------------
module isoch_rx_context_status_tb;
	import isoch_rx_pkg::*;
	logic         clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, bo;
	logic [15:0]  s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]   s_axi_wstrb = 4'hf;
	logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
	logic [3:0]   list_end = 4'h0, fatal_error = 4'h0, pkt_done = 4'h0;
	logic [3:0]   fetch_done, fetch_req, pkt_backout;
	logic [127:0] fetch_next, fetch_addr;
	logic [11:0]  pkt_speed = 12'h0, pkt_outcome = 12'h0;
	logic [4:0]   evt [6] = '{ACK_COMPLETE, ACK_DATA_ERROR, ACK_DATA_ERROR,
		EVT_OVERRUN, EVT_LONG_PACKET, EVT_UNKNOWN};
	int           fails = 0, check_count = 0, i;

	// 50 mhz clock
	always #10 clk = ~clk;

	isoch_rx_context_status i_isoch_rx_context_status (.*);
	isoch_rx_descriptor_memory i_isoch_rx_descriptor_memory (.clk(clk), .sys_rst(sys_rst),
		.slow(slow), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_done(fetch_done), .fetch_next(fetch_next));

	// ------------------------------
	// tasks
	// ------------------------------
	task complete_run;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task check_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	// both channels offered at once, each dropped when taken
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
		if (n == 50)
		begin
			fails++;
			complete_run();
		end
	endtask : axi_write

	task automatic axi_read(input logic [15:0] a);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		if (n == 50)
		begin
			fails++;
			complete_run();
		end
	endtask : axi_read

	// bounded wait on the context 0 fetch request
	task automatic wait_req(input logic v);
		int n;
		for (n = 0; n < 60 && fetch_req[0] !== v; n++)
			@(posedge clk);
		if (n == 60)
		begin
			fails++;
			complete_run();
		end
	endtask : wait_req

	// one received packet, then the status word
	task automatic pkt(input logic [2:0] s, input logic [2:0] o);
		@(posedge clk);
		pkt_speed[2:0] <= s;
		pkt_outcome[2:0] <= o;
		pkt_done[0] <= 1'b1;
		@(posedge clk);
		pkt_done[0] <= 1'b0;
		pkt_speed[2:0] <= ~s;
		pkt_outcome[2:0] <= ~o;
		#1 bo = pkt_backout[0];
		axi_read(CONTROL_BASE);
	endtask : pkt

	// ------------------------------
	// scenarios
	// ------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			axi_read(DESC_PTR_BASE + CONTEXT_STRIDE * 16'(i));
			check_word(rd, 32'h0);
			axi_read(CONTROL_BASE + CONTEXT_STRIDE * 16'(i));
			check_word(rd, 32'h0);
		end
		axi_write(DESC_PTR_BASE, 32'hffff_ffff);
		check_word({30'h0, rs}, 32'h0);
		axi_read(DESC_PTR_BASE);
		check_word(rd, 32'h0);
		axi_read(16'h0480);
		check_word({30'h0, rs}, 32'h2);
		check_word(rd, 32'h0);
		axi_write(16'h0480, 32'h0);
		check_word({30'h0, rs}, 32'h2);
		axi_write(CONTROL_BASE + 16'h0068, 32'h3000);
		axi_read(DESC_PTR_BASE + 16'h0060);
		check_word(rd, 32'h3000);
		// per-buffer mode, every outcome, prompt and slow fetches
		axi_write(CONTROL_BASE + PTR_LOAD_OFS, 32'h1000);
		axi_write(CONTROL_BASE, 32'h8000);
		wait_req(1'b1);
		check_word(fetch_addr[31:0], 32'h1000);
		for (i = 0; i < 6; i++)
		begin
			slow <= i[0];
			wait_req(1'b0);
			axi_read(DESC_PTR_BASE);
			check_word(rd, 32'h1020 + 32'h20 * i);
			pkt(3'(i % 3), 3'(i));
			check_word(rd & 32'h8fff, {16'h0, 8'h84, 3'(i % 3), evt[i]});
		end
		// fatal error while busy, then software stop
		wait_req(1'b0);
		fatal_error[0] <= 1'b1;
		@(posedge clk);
		fatal_error[0] <= 1'b0;
		axi_read(CONTROL_BASE);
		check_word(rd & 32'h8c1f, {16'h0, 8'h88, 3'h0, EVT_DATA_WRITE});
		axi_write(CONTROL_BASE + CONTROL_CLEAR_OFS, 32'h8000);
		axi_read(CONTROL_BASE);
		check_word(rd & 32'h8c00, 32'h0);
		// packed mode backs out bad packets
		axi_write(CONTROL_BASE + PTR_LOAD_OFS, 32'h2000);
		axi_write(CONTROL_BASE, 32'h8000_0000);
		axi_write(CONTROL_BASE, 32'h8000);
		wait_req(1'b1);
		check_word(fetch_addr[31:0], 32'h2000);
		wait_req(1'b0);
		for (i = 0; i < 4; i++)
		begin
			pkt(SPEED_400, 3'(i));
			check_word({31'h0, bo}, {31'h0, i != 0});
			check_word({31'h0, rd[4:0] inside {ACK_COMPLETE, EVT_DESCRIPTOR_READ,
				EVT_DATA_WRITE, EVT_UNKNOWN}}, 32'h1);
		end
		@(posedge clk);
		list_end[0] <= 1'b1;
		@(posedge clk);
		list_end[0] <= 1'b0;
		axi_read(CONTROL_BASE);
		check_word(rd & 32'h8000_8400, 32'h8000_8000);
		// restart, stop while busy, then leave packed mode
		axi_write(CONTROL_BASE, 32'h8000);
		wait_req(1'b1);
		wait_req(1'b0);
		axi_write(CONTROL_BASE + CONTROL_CLEAR_OFS, 32'h8000);
		axi_write(CONTROL_BASE + CONTROL_CLEAR_OFS, 32'h8000_0000);
		axi_read(CONTROL_BASE);
		check_word(rd & 32'h8000_8c00, 32'h0);
		// fatal error during a slow descriptor fetch
		slow <= 1'b1;
		axi_write(CONTROL_BASE, 32'h8000);
		wait_req(1'b1);
		fatal_error[0] <= 1'b1;
		@(posedge clk);
		fatal_error[0] <= 1'b0;
		axi_read(CONTROL_BASE);
		check_word(rd & 32'h8c1f, {16'h0, 8'h88, 3'h0, EVT_DESCRIPTOR_READ});
		complete_run();
	end
endmodule : isoch_rx_context_status_tb
